//--- dtc_defs.vh
// Constants for the DMA channel transfer control block
//
// What this block does
// - Every packet of a transfer moves the byte count in the size field.
// - Handshake-disable set makes the channel ignore request, terminate and done.
// - Lock keeps the arbiter grant until abort, completion, termination in ST_NEXT (not ST_ARB), a bus error, clearing run or no further packet is wanted.
// - Device address grows by packet size per packet when its increment is set.
// - Memory address grows by packet size per packet when its increment is set.
// - Without memory increment only termination, abort, a bus error or clearing run ends a transfer.
// - Seven-bit select picks which handshake bus index paces this channel.
// - Direction one reads memory then writes device; zero the reverse.
// - With memory increment set, memory address reaching end address stops transfer and flags done.
// - Abort ends the transfer at once and releases any lock held outside the idle state.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// Register offsets (byte addresses)
`define DTC_OFF_ACT 8'h00
`define DTC_OFF_MSTART 8'h04
`define DTC_OFF_MEND 8'h08
`define DTC_OFF_DEV 8'h0c
`define DTC_OFF_CTRL 8'h10
`define DTC_OFF_ISTAT 8'h14
`define DTC_OFF_IEN 8'h18
`define DTC_OFF_ICLR 8'h1c

// Control field positions
`define DTC_ABORT 25
`define DTC_GO 24
`define DTC_SIZE_HI 22
`define DTC_SIZE_LO 20
`define DTC_HSDIS 19
`define DTC_LOCK 18
`define DTC_INCDEV 17
`define DTC_INCMEM 16
`define DTC_SEL_HI 15
`define DTC_SEL_LO 9
`define DTC_DIR 8
`define DTC_BUSY 5
`define DTC_STAT_HI 4
`define DTC_STAT_LO 3
`define DTC_DONE 2
`define DTC_REQ 1
`define DTC_RUN 0
// Writable control bits
`define DTC_CTRL_WMASK 32'h037fff01

// Interrupt bits
`define DTC_IRQ_DONE 2
`define DTC_IRQ_FLOW 1
`define DTC_IRQ_BUS 0

// Status codes
`define DTC_ST_ERR 2'h3
`define DTC_ST_TERM 2'h2
`define DTC_ST_LOCAL 2'h1
`define DTC_ST_OFF 2'h0

`endif

//--- dtc_sync.v
// Three-flop input synchroniser with agreement qualification
`timescale 1ns/1ns
`default_nettype none
module dtc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= asyncIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Output changes only when second and third stages agree
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          syncOut[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          syncOut[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- dtc_channel.v
// DMA channel transfer control with register port and memory bus master
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "dtc_defs.vh"
module dtc_channel #(
  parameter NMASTERS = 128,
  parameter AW = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  // Flow-control handshake bus, one bit per master
  input wire [NMASTERS-1:0] hsReq,
  input wire [NMASTERS-1:0] hsTerm,
  output reg [NMASTERS-1:0] hsDone,
  // Channel arbiter
  output reg arbReq,
  output reg arbLock,
  input wire arbGrant,
  // Internal memory bus master
  output reg busValid,
  output reg busWrite,
  output reg [AW-1:0] busAddr,
  output reg [31:0] busWdata,
  output reg [2:0] busSize,
  input wire [31:0] busRdata,
  input wire busAck,
  input wire busErr,
  // Interrupt and status
  output reg irq,
  output reg busy
);

  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ARB = 5'h02;
  localparam [4:0] ST_RD = 5'h04;
  localparam [4:0] ST_WR = 5'h08;
  localparam [4:0] ST_NEXT = 5'h10;

  reg [4:0] state_r;
  reg chanAct_r;
  reg [AW-1:0] memAddr_r;
  reg [AW-1:0] memEnd_r;
  reg [AW-1:0] devAddr_r;
  reg [31:0] ctrl_r;
  reg [2:0] istat_r;
  reg [2:0] ien_r;
  reg [1:0] stat_r;
  reg [31:0] packet_r;
  reg grantHeld_r;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake synchronisation and master selection
  wire [NMASTERS-1:0] reqSync;
  wire [NMASTERS-1:0] termSync;
  dtc_sync #(.W(NMASTERS)) uReqSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(hsReq),
    .syncOut(reqSync)
  );
  dtc_sync #(.W(NMASTERS)) uTermSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(hsTerm),
    .syncOut(termSync)
  );

  wire [6:0] sel = ctrl_r[`DTC_SEL_HI:`DTC_SEL_LO];
  wire hsOn = ~ctrl_r[`DTC_HSDIS];
  // Handshake ignored entirely when disabled selected index paces
  wire selReq = hsOn & reqSync[sel];
  wire selTerm = hsOn & termSync[sel];
  wire running = chanAct_r & ctrl_r[`DTC_RUN];
  wire fwGo = ctrl_r[`DTC_HSDIS] & ctrl_r[`DTC_GO];
  wire abort = ctrl_r[`DTC_ABORT];
  wire [2:0] pktSize = ctrl_r[`DTC_SIZE_HI:`DTC_SIZE_LO];
  wire incMem = ctrl_r[`DTC_INCMEM];
  wire incDev = ctrl_r[`DTC_INCDEV];
  wire dirMemToDev = ctrl_r[`DTC_DIR];
  // Local completion only counts when memory address increments
  wire atEnd = incMem & (memAddr_r == memEnd_r);
  wire [AW-1:0] sizeExt = {{(AW-3){1'b0}}, pktSize};
  wire wantPkt = running & (selReq | fwGo);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  wire wrCtrl = regWr & (regAddr == `DTC_OFF_CTRL);
  wire wrMs = regWr & (regAddr == `DTC_OFF_MSTART);
  wire wrDev = regWr & (regAddr == `DTC_OFF_DEV);
  reg [2:0] setIrq;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      memAddr_r <= {AW{1'b0}};
      devAddr_r <= {AW{1'b0}};
      packet_r <= 32'h00000000;
      stat_r <= `DTC_ST_OFF;
      grantHeld_r <= 1'b0;
      arbReq <= 1'b0;
      arbLock <= 1'b0;
      busValid <= 1'b0;
      busWrite <= 1'b0;
      busAddr <= {AW{1'b0}};
      busWdata <= 32'h00000000;
      busSize <= 3'h0;
      hsDone <= {NMASTERS{1'b0}};
      setIrq <= 3'h0;
    end else begin
      setIrq <= 3'h0;
      hsDone <= {NMASTERS{1'b0}};
      if (wrMs) begin
        memAddr_r <= regWdata[AW-1:0];
      end
      if (wrDev) begin
        devAddr_r <= regWdata[AW-1:0];
      end
      if (!running) begin
        stat_r <= `DTC_ST_OFF;
      end
      // Abort outside the idle state ends everything at once and drops the lock
      if (abort && state_r != ST_IDLE) begin
        state_r <= ST_IDLE;
        busValid <= 1'b0;
        arbReq <= 1'b0;
        arbLock <= 1'b0;
        grantHeld_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (running && selTerm) begin
              stat_r <= `DTC_ST_TERM;
            end else if (wantPkt && atEnd) begin
              // Request after completion: overflow attempt
              setIrq[`DTC_IRQ_FLOW] <= selReq;
            end else if (wantPkt) begin
              arbReq <= 1'b1;
              state_r <= ST_ARB;
            end
          end
          ST_ARB: begin
            if (selTerm) begin
              arbReq <= 1'b0;
              stat_r <= `DTC_ST_TERM;
              state_r <= ST_IDLE;
            end else if (arbGrant || grantHeld_r) begin
              grantHeld_r <= ctrl_r[`DTC_LOCK];
              arbLock <= ctrl_r[`DTC_LOCK];
              busValid <= 1'b1;
              busWrite <= 1'b0;
              // Source side chosen by direction
              busAddr <= dirMemToDev ? memAddr_r : devAddr_r;
              busSize <= pktSize;
              state_r <= ST_RD;
            end
          end
          ST_RD: begin
            if (busErr) begin
              busValid <= 1'b0;
              setIrq[`DTC_IRQ_BUS] <= 1'b1;
              stat_r <= `DTC_ST_ERR;
              state_r <= ST_NEXT;
            end else if (busAck) begin
              packet_r <= busRdata;
              busWrite <= 1'b1;
              busWdata <= busRdata;
              busAddr <= dirMemToDev ? devAddr_r : memAddr_r;
              state_r <= ST_WR;
            end
          end
          ST_WR: begin
            if (busErr) begin
              busValid <= 1'b0;
              setIrq[`DTC_IRQ_BUS] <= 1'b1;
              stat_r <= `DTC_ST_ERR;
              state_r <= ST_NEXT;
            end else if (busAck) begin
              busValid <= 1'b0;
              busWrite <= 1'b0;
              if (incMem) begin
                memAddr_r <= memAddr_r + sizeExt;
              end
              if (incDev) begin
                devAddr_r <= devAddr_r + sizeExt;
              end
              hsDone[sel] <= hsOn;
              state_r <= ST_NEXT;
            end
          end
          ST_NEXT: begin
            if (stat_r == `DTC_ST_ERR) begin
              arbReq <= 1'b0;
              arbLock <= 1'b0;
              grantHeld_r <= 1'b0;
              state_r <= ST_IDLE;
            end else if (atEnd) begin
              arbReq <= 1'b0;
              arbLock <= 1'b0;
              grantHeld_r <= 1'b0;
              stat_r <= `DTC_ST_LOCAL;
              setIrq[`DTC_IRQ_DONE] <= 1'b1;
              state_r <= ST_IDLE;
            end else if (selTerm || !running) begin
              arbReq <= 1'b0;
              arbLock <= 1'b0;
              grantHeld_r <= 1'b0;
              if (selTerm) begin
                stat_r <= `DTC_ST_TERM;
              end
              state_r <= ST_IDLE;
            end else if (wantPkt && grantHeld_r) begin
              state_r <= ST_ARB;
            end else begin
              // Without lock the grant is given back between packets
              arbReq <= wantPkt;
              grantHeld_r <= 1'b0;
              state_r <= wantPkt ? ST_ARB : ST_IDLE;
              arbLock <= 1'b0;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, interrupts and read port
  wire wrIclr = regWr & (regAddr == `DTC_OFF_ICLR);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chanAct_r <= 1'b0;
      memEnd_r <= {AW{1'b0}};
      ctrl_r <= 32'h00000000;
      istat_r <= 3'h0;
      ien_r <= 3'h0;
      regRdata <= 32'h00000000;
      irq <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (regWr && regAddr == `DTC_OFF_ACT) begin
        chanAct_r <= regWdata[0];
      end
      if (regWr && regAddr == `DTC_OFF_MEND) begin
        memEnd_r <= regWdata[AW-1:0];
      end
      if (wrCtrl) begin
        ctrl_r <= regWdata & `DTC_CTRL_WMASK;
      end else if (abort && state_r == ST_IDLE) begin
        ctrl_r[`DTC_ABORT] <= 1'b0;
      end
      if (regWr && regAddr == `DTC_OFF_IEN) begin
        ien_r <= regWdata[2:0];
      end
      // Set wins over a clear in the same cycle
      istat_r <= (istat_r & ~(wrIclr ? regWdata[2:0] : 3'h0)) | setIrq;
      irq <= |(istat_r & ien_r);
      busy <= (state_r != ST_IDLE);
      regRdata <= 32'h00000000;
      if (regRd) begin
        if (regAddr == `DTC_OFF_ACT) begin
          regRdata <= {31'h00000000, chanAct_r};
        end else if (regAddr == `DTC_OFF_MSTART) begin
          regRdata[AW-1:0] <= memAddr_r;
        end else if (regAddr == `DTC_OFF_MEND) begin
          regRdata[AW-1:0] <= memEnd_r;
        end else if (regAddr == `DTC_OFF_DEV) begin
          regRdata[AW-1:0] <= devAddr_r;
        end else if (regAddr == `DTC_OFF_CTRL) begin
          regRdata <= {ctrl_r[31:6], (state_r != ST_IDLE), stat_r,
                       running & (state_r == ST_IDLE), selReq, ctrl_r[`DTC_RUN]};
        end else if (regAddr == `DTC_OFF_ISTAT) begin
          regRdata <= {29'h00000000, istat_r};
        end else if (regAddr == `DTC_OFF_IEN) begin
          regRdata <= {29'h00000000, ien_r};
        end else begin
          regRdata <= 32'h00000000;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- dtc_channel_assertions.sv
// Assertion checker for the DMA channel transfer control block
`timescale 1ns/1ns
`default_nettype none
module dtc_channel_assertions #(
  parameter NMASTERS = 128,
  parameter AW = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  // Handshake and arbiter
  input wire [NMASTERS-1:0] hsDone,
  input wire arbLock,
  // Memory bus
  input wire busValid,
  input wire busWrite,
  input wire [AW-1:0] busAddr,
  input wire [2:0] busSize,
  input wire busAck,
  input wire busErr,
  // Status
  input wire busy
);
  ////////////////////////////////////////////////////////////////
  // Shadow of the control register
  reg [31:0] ctrl_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 32'h0;
    end else if (regWr && regAddr == 8'h10) begin
      ctrl_r <= regWdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  property p_size; busValid |-> busSize == ctrl_r[22:20]; endproperty
  a_size: assert property (p_size) else $error("packet size differs");
  property p_hsdis; ctrl_r[19] |-> hsDone == '0; endproperty
  a_hsdis: assert property (p_hsdis) else $error("done while disabled");
  property p_lock; ctrl_r[18] && busValid |-> arbLock; endproperty
  a_lock: assert property (p_lock) else $error("lock missing");
  property p_order;
    busValid && !busWrite && busAck && !ctrl_r[25] |=> busValid && busWrite;
  endproperty
  a_order: assert property (p_order) else $error("write not after read");
  property p_hold;
    busValid && !busAck && !busErr && !ctrl_r[25] |=>
      busValid && $stable(busAddr) && $stable(busWrite);
  endproperty
  a_hold: assert property (p_hold) else $error("bus request dropped");
  property p_sel;
    hsDone != '0 |-> hsDone == ({{(NMASTERS-1){1'b0}}, 1'b1} << ctrl_r[15:9]);
  endproperty
  a_sel: assert property (p_sel) else $error("done on wrong index");
  property p_pulse; hsDone != '0 |-> $past(busValid && busWrite && busAck); endproperty
  a_pulse: assert property (p_pulse) else $error("done without packet");
  property p_abort;
    regWr && regAddr == 8'h10 && regWdata[25] |-> ##[1:3] !busy && !arbLock;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");
endmodule
bind dtc_channel dtc_channel_assertions #(.NMASTERS(NMASTERS), .AW(AW)) u_chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .hsDone(hsDone), .arbLock(arbLock), .busValid(busValid), .busWrite(busWrite),
  .busAddr(busAddr), .busSize(busSize), .busAck(busAck), .busErr(busErr), .busy(busy));
`default_nettype wire

//--- dtc_periph_model.sv
// Pacing master model on the handshake bus
`timescale 1ns/1ns
`default_nettype none
module dtc_periph_model #(
  parameter N = 128
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bench control
  input wire [6:0] sel,
  input wire want,
  input wire stop,
  // Handshake bus
  input wire [N-1:0] hsDone,
  output wire [N-1:0] hsReq,
  output wire [N-1:0] hsTerm,
  output logic [15:0] doneCnt
);
  // Request held per packet, terminate ends early
  assign hsReq = {{(N-1){1'b0}}, want} << sel;
  assign hsTerm = {{(N-1){1'b0}}, stop} << sel;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneCnt <= 16'h0;
    end else if (hsDone[sel]) begin
      doneCnt <= doneCnt + 16'h1;
    end
  end
endmodule
`default_nettype wire

//--- dtc_channel_tb.sv
// Testbench for the DMA channel transfer control block
`timescale 1ns/1ns
`default_nettype none
module dtc_channel_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] busRdata = 32'h0;
  logic busAck = 1'b0;
  logic arbGrant = 1'b0;
  logic [6:0] sel = 7'h0;
  logic want = 1'b0;
  logic stop = 1'b0;
  logic [31:0] regRdata, busAddr, busWdata, rdv, lastRd, lastWr, m, d, cfg, rdData;
  logic [127:0] hsReq, hsTerm, hsDone;
  logic arbReq, arbLock, busValid, busWrite, irq, busy;
  logic [2:0] busSize, sz;
  logic [15:0] doneCnt;
  logic [2:0] szTab [3] = '{3'h1, 3'h2, 3'h4};
  int errors = 0;
  int checks_done = 0;
  int pk = 0;
  int n;
  dtc_channel u_dtc_channel (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .hsReq(hsReq), .hsTerm(hsTerm), .hsDone(hsDone), .arbReq(arbReq), .arbLock(arbLock),
    .arbGrant(arbGrant), .busValid(busValid), .busWrite(busWrite), .busAddr(busAddr),
    .busWdata(busWdata), .busSize(busSize), .busRdata(busRdata), .busAck(busAck),
    .busErr(1'b0), .irq(irq), .busy(busy));
  dtc_periph_model u_dtc_periph_model (.clk(clk), .rst_n(rst_n), .sel(sel), .want(want),
    .stop(stop), .hsDone(hsDone), .hsReq(hsReq), .hsTerm(hsTerm), .doneCnt(doneCnt));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // Arbiter and memory slave with random wait states
  always @(posedge clk) begin
    arbGrant <= arbReq;
    busAck <= busValid && !busAck && ($urandom % 2 == 0);
    busRdata <= $urandom;
    if (busValid && busAck && busWrite) begin
      pk <= pk + 1;
      lastWr <= busAddr;
    end
    if (busValid && busAck && busWrite) chk("wdata", rdData, busWdata);
    if (busValid && busAck && !busWrite) begin
      lastRd <= busAddr;
      rdData <= busRdata;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic idle;
    repeat (12) @(posedge clk);
    repeat (3000) if (busy !== 1'b0) @(posedge clk);
  endtask
  task close_out;
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    close_out;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9a3c5c94));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h10);
    chk("ctrl", 32'h0, rdv);
    rd(8'h40);
    chk("unmapped", 32'h0, rdv);
    wr(8'h00, 32'h1);
    wr(8'h18, 32'h4);
    // Firmware paced, memory to device, every legal size
    for (int i = 0; i < 3; i++) begin
      sz = szTab[i];
      n = 2 + $urandom % 4;
      m = {16'h0, 16'($urandom)} & 32'hfffc;
      d = m + 32'h10000;
      pk = 0;
      wr(8'h04, m);
      wr(8'h08, m + n * sz);
      wr(8'h0c, d);
      wr(8'h10, {8'h01, 1'b0, sz, 4'hb, 7'h0, 1'b1, 8'h01});
      idle;
      wr(8'h10, 32'h0);
      chk("packets", n, pk);
      chk("read addr", m + (n - 1) * sz, lastRd);
      chk("write addr", d + (n - 1) * sz, lastWr);
      rd(8'h04);
      chk("mem addr", m + n * sz, rdv);
      rd(8'h14);
      chk("istat", 32'h4, rdv);
      chk("irq on", 1, irq);
      wr(8'h1c, 32'h4);
      repeat (2) @(posedge clk);
      #1 chk("irq off", 0, irq);
    end
    // Hardware paced with lock, no memory increment, end equals start
    sel <= 7'($urandom);
    sz = szTab[$urandom % 3];
    pk = 0;
    wr(8'h04, m);
    wr(8'h08, m);
    wr(8'h0c, d);
    cfg = {8'h00, 1'b0, sz, 4'h6, sel, 1'b0, 8'h00};
    wr(8'h10, cfg | 32'h1);
    want <= 1'b1;
    repeat (150) @(posedge clk);
    want <= 1'b0;
    stop <= 1'b1;
    idle;
    stop <= 1'b0;
    chk("many packets", 1, pk > 2);
    chk("done pulses", pk, doneCnt);
    rd(8'h0c);
    chk("dev addr", d + pk * sz, rdv);
    rd(8'h04);
    chk("mem fixed", m, rdv);
    rd(8'h14);
    chk("no done flag", 0, rdv[2]);
    // Disabled handshake ignores requests
    wr(8'h10, cfg | 32'h80001);
    want <= 1'b1;
    repeat (30) @(posedge clk);
    chk("ignored", 0, busy);
    // Abort in mid-transfer
    wr(8'h10, cfg | 32'h1);
    repeat (300) if (busValid !== 1'b1) @(posedge clk);
    wr(8'h10, cfg | 32'h2000000);
    repeat (3) @(posedge clk);
    chk("abort idle", 0, busy);
    chk("lock free", 0, arbLock);
    want <= 1'b0;
    rd(8'h10);
    chk("abort clear", 0, rdv[25]);
    close_out;
  end
endmodule
`default_nettype wire
